/* File: verilog/spvp_defines.svh */
// Purpose: constants of the serial program/verify port
// Assumes: 40 MHz core clock
// Notes:   counts, command codes and address limits
`ifndef SPVP_DEFINES_SVH
`define SPVP_DEFINES_SVH
`define SPVP_CMD_BITS        6
`define SPVP_FRAME_BITS      16
`define SPVP_WORD_BITS       14
`define SPVP_PC_BITS         14
`define SPVP_MEM_ADDR_BITS   10
`define SPVP_CFG_ADDR_BITS   4
`define SPVP_CMD_LOAD_CFG    6'h00
`define SPVP_CMD_LOAD_DATA   6'h02
`define SPVP_CMD_READ_DATA   6'h04
`define SPVP_CMD_INC_ADDR    6'h06
`define SPVP_CMD_BEGIN_PROG  6'h08
`define SPVP_PC_CFG_BASE     14'h2000
`define SPVP_PC_CFG_BIT      13
`define SPVP_PC_CFG_WIN_MASK 14'h1ff0
`define SPVP_ID_LAST         4'h3
`define SPVP_ERASED_WORD     14'h3fff
`define SPVP_CLK_PERIOD_NS   25
`define SPVP_PROG_TIME_NS    100000
`define SPVP_PROG_CYCLES     ((`SPVP_PROG_TIME_NS + `SPVP_CLK_PERIOD_NS - 1) / `SPVP_CLK_PERIOD_NS)
`endif

/* File: verilog/spvp_pkg.sv */
// Purpose: types shared by the serial program/verify port
// Assumes: constants live in spvp_defines.svh
// Notes:   nothing here is imported
package spvp_pkg;
  typedef enum logic [2:0] {
    ST_CMD, ST_GAP, ST_LOAD, ST_READ, ST_PROG
  } spvp_state_type;
  typedef struct packed {
    logic rise;
    logic fall;
    logic level;
  } spvp_edge_type;
endpackage

/* File: verilog/spvp_pin_sync.sv */
// Purpose: three-stage pin synchroniser with edge detection
// Assumes: pin asynchronous to mclk_i
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module spvp_pin_sync (
  // clock and reset
  input  wire logic                   mclk_i,
  input  wire logic                   rst_b_i,
  // pin and result
  input  wire logic                   pin_i,
  output spvp_pkg::spvp_edge_type     edge_o
);
  logic [2:0] stage;
  logic       agreed;
  // a change counts once stages two and three agree
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      stage  <= 3'h0;
      agreed <= 1'b0;
    end else begin
      stage  <= {stage[1:0], pin_i};
      if (stage[1] == stage[2]) agreed <= stage[2];
    end
  end
  wire logic next_level = (stage[1] == stage[2]) ? stage[2] : agreed;
  assign edge_o.level = agreed;
  assign edge_o.rise  = next_level & ~agreed;
  assign edge_o.fall  = ~next_level & agreed;
endmodule

/* File: verilog/spvp_port.sv */
// Purpose: device end of the serial program/verify port
// Assumes: link clock sampled by mclk_i; mode_select_hv_i flags the high voltage
// Notes:   memories modelled as arrays; program timed internally
//
// Function
// - in mode, rest of device held in reset, general pins float
// - command is six clocks, bits taken on falling edge, lsb first
// - data frame is 16 clocks: start, 14 payload lsb first, stop
// - read drives lsb on second rising edge; load takes it on second fall
// - outgoing bits launch on rising edges, incoming sampled on falling edges
// - user space aliases onto 1024 words by low ten counter bits
// - counter wraps 1fff to 0000 and 3fff to 2000
// - counter top bit stays set once in configuration space
// - config 2000-200f implemented, beyond that reaches user memory
// - four id words at 2000 to 2003
// - id words read back plain even with protection on
// - load configuration sets counter to 2000 then takes a 14-bit word
// - only leaving the mode returns counter to user space
// - load program data takes a 14-bit word from the next frame
// - command codes 00,02,04,06,08 are decoded
// - read drives pin from second rising edge until after sixteenth
// - increment advances counter by one under wrap rules
// - begin programming erases then writes the loaded word, self-timed
`timescale 1ns/1ps
`include "spvp_defines.svh"
module spvp_port #(
  parameter int PROG_CYCLES = `SPVP_PROG_CYCLES
) (
  // clock and reset
  input  wire logic                          mclk_i,
  input  wire logic                          rst_b_i,
  // programming pins
  input  wire logic                          mode_select_hv_i,
  input  wire logic                          prog_clock_pin_i,
  input  wire logic                          prog_data_pin_i,
  output logic                               prog_data_pin_o,
  output logic                               prog_data_pin_oe_o,
  // device status
  input  wire logic                          code_protect_i,
  output logic                               core_reset_o,
  output logic                               prog_busy_o
);
  // the program timer is 17 bits wide, so longer cycles cannot be counted
  if (PROG_CYCLES < 1 || PROG_CYCLES > 131071) begin : g_prog_cycles_check
    $error("PROG_CYCLES must lie between 1 and 131071");
  end

  spvp_pkg::spvp_edge_type clk_e;
  spvp_pkg::spvp_edge_type dat_e;
  spvp_pkg::spvp_edge_type mode_e;
  spvp_pin_sync u_clk  (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .pin_i(prog_clock_pin_i), .edge_o(clk_e));
  spvp_pin_sync u_dat  (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .pin_i(prog_data_pin_i),  .edge_o(dat_e));
  spvp_pin_sync u_mode (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .pin_i(mode_select_hv_i), .edge_o(mode_e));

  logic [`SPVP_WORD_BITS-1:0]  user_mem [0:(1<<`SPVP_MEM_ADDR_BITS)-1];
  logic [`SPVP_WORD_BITS-1:0]  cfg_mem  [0:(1<<`SPVP_CFG_ADDR_BITS)-1];
  spvp_pkg::spvp_state_type    state;
  logic [4:0]                  bit_cnt;
  logic [`SPVP_CMD_BITS-1:0]   cmd_sr;
  logic [`SPVP_CMD_BITS-1:0]   cmd;
  logic [`SPVP_FRAME_BITS-1:0] frame_sr;
  logic [`SPVP_WORD_BITS-1:0]  latch;
  logic [`SPVP_WORD_BITS-1:0]  rd_word;
  logic [`SPVP_PC_BITS-1:0]    pc;
  logic [16:0]                 prog_cnt;
  logic                        in_mode;
  logic                        dout;
  logic                        oe;

  // decoding used for both access and writing
  function automatic logic to_cfg(input logic [`SPVP_PC_BITS-1:0] a);
    to_cfg = a[`SPVP_PC_CFG_BIT] && ((a & `SPVP_PC_CFG_WIN_MASK) == 14'h0000);
  endfunction

  wire logic in_cfg   = to_cfg(pc);
  wire logic [`SPVP_MEM_ADDR_BITS-1:0] uaddr = pc[`SPVP_MEM_ADDR_BITS-1:0];
  wire logic [`SPVP_CFG_ADDR_BITS-1:0] caddr = pc[`SPVP_CFG_ADDR_BITS-1:0];
  wire logic is_id    = in_cfg && (caddr <= `SPVP_ID_LAST);
  // protected user words read as zero; id and config words stay plain
  wire logic hide     = code_protect_i && !in_cfg;
  wire logic [`SPVP_WORD_BITS-1:0] mem_word = in_cfg ? cfg_mem[caddr] : user_mem[uaddr];
  wire logic [`SPVP_PC_BITS-1:0] pc_inc = {pc[`SPVP_PC_CFG_BIT], pc[`SPVP_PC_CFG_BIT-1:0] + 13'h0001};
  wire logic has_data = (cmd == `SPVP_CMD_LOAD_CFG) || (cmd == `SPVP_CMD_LOAD_DATA)
                     || (cmd == `SPVP_CMD_READ_DATA);
  wire logic cmd_done = (state == spvp_pkg::ST_CMD) && clk_e.fall && (bit_cnt == 5'd5);
  wire logic [`SPVP_CMD_BITS-1:0] cmd_full = {dat_e.level, cmd_sr[`SPVP_CMD_BITS-1:1]};
  wire logic frame_end = clk_e.fall && (bit_cnt == 5'd15);

  // mode tracking; leaving the mode puts the counter back in user space
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) in_mode <= 1'b0;
    else          in_mode <= mode_e.level;
  end

  // command, frame and program sequencer
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i || !in_mode) begin
      state    <= spvp_pkg::ST_CMD;
      bit_cnt  <= 5'd0;
      cmd_sr   <= 6'h00;
      cmd      <= 6'h3f;
      frame_sr <= 16'h0000;
      pc       <= 14'h0000;
      prog_cnt <= 17'h00000;
      rd_word  <= 14'h0000;
    end else begin
      case (state)
        spvp_pkg::ST_CMD: begin
          if (clk_e.fall) begin
            cmd_sr  <= cmd_full;
            bit_cnt <= bit_cnt + 5'd1;
          end
          if (cmd_done) begin
            cmd     <= cmd_full;
            bit_cnt <= 5'd0;
            state   <= spvp_pkg::ST_GAP;
          end
        end
        spvp_pkg::ST_GAP: begin
          // decode in the gap the programmer leaves after the command
          state <= spvp_pkg::ST_CMD;
          if (cmd == `SPVP_CMD_LOAD_CFG) pc <= `SPVP_PC_CFG_BASE;
          if (cmd == `SPVP_CMD_INC_ADDR) pc <= pc_inc;
          if (has_data) state <= (cmd == `SPVP_CMD_READ_DATA) ? spvp_pkg::ST_READ : spvp_pkg::ST_LOAD;
          if (cmd == `SPVP_CMD_READ_DATA) rd_word <= hide ? 14'h0000 : mem_word;
          if (cmd == `SPVP_CMD_BEGIN_PROG) begin
            state    <= spvp_pkg::ST_PROG;
            prog_cnt <= 17'(PROG_CYCLES);
          end
        end
        spvp_pkg::ST_LOAD, spvp_pkg::ST_READ: begin
          if (clk_e.fall) begin
            frame_sr <= {dat_e.level, frame_sr[`SPVP_FRAME_BITS-1:1]};
            bit_cnt  <= bit_cnt + 5'd1;
          end
          if (frame_end) begin
            bit_cnt <= 5'd0;
            state   <= spvp_pkg::ST_CMD;
          end
        end
        default: begin
          prog_cnt <= prog_cnt - 17'd1;
          if (prog_cnt == 17'd1) state <= spvp_pkg::ST_CMD;
        end
      endcase
    end
  end

  // payload latch keeps only the 14 bits between start and stop
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) latch <= `SPVP_ERASED_WORD;
    else if (state == spvp_pkg::ST_LOAD && frame_end)
      latch <= frame_sr[`SPVP_FRAME_BITS-1:2];
  end

  // erase then write at the end of the timed cycle; memory holds no reset
  always_ff @(posedge mclk_i) begin
    if (rst_b_i && in_mode && state == spvp_pkg::ST_PROG && prog_cnt == 17'd1) begin
      if (in_cfg) cfg_mem[caddr] <= latch;
      else        user_mem[uaddr] <= latch;
    end
  end

  // read drive: lsb from 2nd rise, released after 16th rise
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i || !in_mode || state != spvp_pkg::ST_READ) begin
      oe   <= 1'b0;
      dout <= 1'b0;
    end else if (clk_e.rise) begin
      oe   <= (bit_cnt >= 5'd1) && (bit_cnt <= 5'd14);
      dout <= (bit_cnt >= 5'd1 && bit_cnt <= 5'd14) ? rd_word[4'(bit_cnt - 5'd1)] : 1'b0;
    end
  end

  assign prog_data_pin_o    = dout;
  assign prog_data_pin_oe_o = oe;
  assign core_reset_o       = in_mode;
  assign prog_busy_o        = (state == spvp_pkg::ST_PROG);

  property p_cfg_sticky;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (in_mode && pc[`SPVP_PC_CFG_BIT]) ##1 in_mode |-> pc[`SPVP_PC_CFG_BIT];
  endproperty
  a_cfg_sticky: assert property (p_cfg_sticky) else $error("config bit dropped");

  property p_load_cfg;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (in_mode && state == spvp_pkg::ST_GAP && cmd == `SPVP_CMD_LOAD_CFG) |=> pc == `SPVP_PC_CFG_BASE;
  endproperty
  a_load_cfg: assert property (p_load_cfg) else $error("load config did not set counter");

  property p_inc;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (in_mode && state == spvp_pkg::ST_GAP && cmd == `SPVP_CMD_INC_ADDR)
      |=> pc[`SPVP_PC_CFG_BIT-1:0] == $past(pc[`SPVP_PC_CFG_BIT-1:0]) + 13'h0001
          && pc[`SPVP_PC_CFG_BIT] == $past(pc[`SPVP_PC_CFG_BIT]);
  endproperty
  a_inc: assert property (p_inc) else $error("increment wrong");

  property p_wrap;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (in_mode && state == spvp_pkg::ST_GAP && cmd == `SPVP_CMD_INC_ADDR && pc[`SPVP_PC_CFG_BIT])
      |=> pc[`SPVP_PC_CFG_BIT] && ($past(pc) != 14'h3fff || pc == `SPVP_PC_CFG_BASE);
  endproperty
  a_wrap: assert property (p_wrap) else $error("config wrap wrong");

  property p_unknown;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (in_mode && state == spvp_pkg::ST_GAP && !has_data && cmd != `SPVP_CMD_INC_ADDR
       && cmd != `SPVP_CMD_BEGIN_PROG && cmd != `SPVP_CMD_LOAD_CFG) |=> $stable(pc) && !oe;
  endproperty
  a_unknown: assert property (p_unknown) else $error("unknown command had effect");

  property p_oe_read;
    @(posedge mclk_i) disable iff (!rst_b_i) oe |-> state == spvp_pkg::ST_READ;
  endproperty
  a_oe_read: assert property (p_oe_read) else $error("pin driven outside read");

  property p_mode_reset;
    @(posedge mclk_i) disable iff (!rst_b_i)
      $rose(in_mode) |-> core_reset_o && !oe && state == spvp_pkg::ST_CMD && pc == 14'h0000;
  endproperty
  a_mode_reset: assert property (p_mode_reset) else $error("core not held");

  // id words bypass the protection mask
  property p_id_plain;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (in_mode && state == spvp_pkg::ST_GAP && cmd == `SPVP_CMD_READ_DATA && is_id)
      |=> rd_word == $past(mem_word);
  endproperty
  a_id_plain: assert property (p_id_plain) else $error("id word not read plain");

  property p_cmd_len;
    @(posedge mclk_i) disable iff (!rst_b_i)
      (in_mode && state == spvp_pkg::ST_CMD && cmd_done) |=> state == spvp_pkg::ST_GAP && bit_cnt == 5'd0;
  endproperty
  a_cmd_len: assert property (p_cmd_len) else $error("command length wrong");

  property p_prog_time;
    @(posedge mclk_i) disable iff (!rst_b_i || !in_mode)
      $rose(prog_busy_o) |-> prog_busy_o [*8];
  endproperty
  a_prog_time: assert property (p_prog_time) else $error("program cycle too short");
endmodule

/* File: sim/spvp_prog_model.sv */
// Purpose: behavioural programmer driving the far end of the port
// Assumes: link period 200 ns, pins change only on mclk falling edges
// Notes:   link clock stands low outside frames
`timescale 1ns/1ps
module spvp_prog_model (
  // core clock used for pacing only
  input  wire logic mclk_i,
  // link pins
  input  wire logic data_pin_i,
  output logic      clk_o,
  output logic      data_o,
  output logic      data_oe_o,
  output logic      hv_o
);
  initial begin
    clk_o = 1'b0;
    data_o = 1'b0;
    data_oe_o = 1'b1;
    hv_o = 1'b0;
  end
  task automatic wait_mclk(input int n);
    repeat (n) @(negedge mclk_i);
  endtask
  // data launched with the rise, held through the fall
  task automatic link_cycle(input logic b, output logic s);
    wait_mclk(1);
    s = data_pin_i;
    clk_o = 1'b1;
    data_o = b;
    wait_mclk(4);
    clk_o = 1'b0;
    wait_mclk(3);
  endtask
  // clock and data low while the high voltage comes up
  task automatic enter();
    clk_o = 1'b0;
    data_o = 1'b0;
    wait_mclk(8);
    hv_o = 1'b1;
    wait_mclk(20);
  endtask
  task automatic leave();
    hv_o = 1'b0;
    wait_mclk(20);
  endtask
  // gap after the command covers decode and pin turnaround
  task automatic send_cmd(input logic [5:0] c, input int gap);
    logic s;
    for (int i = 0; i < 6; i++) begin
      link_cycle(c[i], s);
    end
    wait_mclk(gap);
  endtask
  // start and stop sent as ones so that discarding them is visible
  task automatic load_word(input logic [13:0] w);
    logic [15:0] f;
    logic        s;
    f = {1'b1, w, 1'b1};
    for (int c = 0; c < 16; c++) begin
      link_cycle(f[c], s);
    end
    wait_mclk(48);
  endtask
  // released line shows the inverse of our last value
  task automatic read_word(output logic [13:0] w);
    logic s;
    wait_mclk(1);
    data_oe_o = 1'b0;
    for (int c = 0; c < 16; c++) begin
      link_cycle(data_o, s);
      if (c >= 2) begin
        w[c-2] = s;
      end
    end
    wait_mclk(48);
    data_oe_o = 1'b1;
  endtask
endmodule

/* File: sim/spvp_port_tb_top.sv */
// Purpose: self-checking bench for the program/verify port
// Assumes: short program time via PROG_CYCLES
// Notes:   memories start unknown, so only written words are read
`timescale 1ns/1ps
`include "spvp_defines.svh"
module spvp_port_tb_top;
  localparam int PROG_N = 12;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic protect = 1'b0;
  logic clk_pin;
  logic hv;
  logic p_out;
  logic p_oe;
  logic d_out;
  logic d_oe;
  logic core_rst;
  logic busy;
  int   n_mismatch = 0;
  int   comparisons = 0;
  // resolved data line, device first
  wire  data_pin = d_oe ? d_out : (p_oe ? p_out : ~p_out);
  always #12.5 mclk = ~mclk;
  spvp_port #(.PROG_CYCLES(PROG_N)) i_dut (
    .mclk_i(mclk), .rst_b_i(rst_b), .mode_select_hv_i(hv), .prog_clock_pin_i(clk_pin),
    .prog_data_pin_i(data_pin), .prog_data_pin_o(d_out), .prog_data_pin_oe_o(d_oe),
    .code_protect_i(protect), .core_reset_o(core_rst), .prog_busy_o(busy));
  spvp_prog_model i_prog (
    .mclk_i(mclk), .data_pin_i(data_pin), .clk_o(clk_pin), .data_o(p_out),
    .data_oe_o(p_oe), .hv_o(hv));
  task automatic check(input string what, input logic [13:0] seen, input logic [13:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // busy must rise, last the full count, then fall
  task automatic prog_cycle();
    int n;
    i_prog.send_cmd(`SPVP_CMD_BEGIN_PROG, 0);
    n = 0;
    while (busy !== 1'b1 && n < 40) begin
      @(negedge mclk);
      n++;
    end
    check("busy_rise", {13'h0, busy}, 14'h1);
    if (busy !== 1'b1) begin
      final_report();
    end
    n = 0;
    while (busy === 1'b1 && n < PROG_N + 40) begin
      @(negedge mclk);
      n++;
    end
    check("busy_len", 14'(n), 14'(PROG_N));
    if (busy !== 1'b0) begin
      final_report();
    end
    i_prog.wait_mclk(48);
  endtask
  task automatic read_at(input string what, input logic [13:0] exp);
    logic [13:0] w;
    i_prog.send_cmd(`SPVP_CMD_READ_DATA, 48);
    i_prog.read_word(w);
    check(what, w, exp);
    check("oe_after_read", {13'h0, d_oe}, 14'h0);
  endtask
  // load, program, verify
  task automatic write_word(input logic [5:0] cmd, input logic [13:0] w);
    i_prog.send_cmd(cmd, 48);
    i_prog.load_word(w);
    prog_cycle();
    read_at("verify", w);
  endtask
  task automatic t_entry();
    i_prog.enter();
    check("core_reset", {13'h0, core_rst}, 14'h1);
    check("oe_idle", {13'h0, d_oe}, 14'h0);
  endtask
  task automatic t_user();
    write_word(`SPVP_CMD_LOAD_DATA, 14'h1a5c);
    i_prog.send_cmd(`SPVP_CMD_INC_ADDR, 48);
    write_word(`SPVP_CMD_LOAD_DATA, 14'h0731);
  endtask
  task automatic t_reenter();
    i_prog.leave();
    check("core_release", {13'h0, core_rst}, 14'h0);
    i_prog.enter();
    read_at("addr0", 14'h1a5c);
    i_prog.send_cmd(`SPVP_CMD_INC_ADDR, 48);
    read_at("addr1", 14'h0731);
  endtask
  // unknown codes leave counter, memory and pin alone
  task automatic t_unknown();
    i_prog.send_cmd(6'h3f, 48);
    check("oe_unknown", {13'h0, d_oe}, 14'h0);
    i_prog.send_cmd(6'h01, 48);
    read_at("after_unknown", 14'h0731);
  endtask
  task automatic t_config();
    write_word(`SPVP_CMD_LOAD_CFG, 14'h3f81);
    i_prog.send_cmd(`SPVP_CMD_INC_ADDR, 48);
    write_word(`SPVP_CMD_LOAD_DATA, 14'h3f82);
    @(negedge mclk);
    protect = 1'b1;
    read_at("id_protected", 14'h3f82);
    @(negedge mclk);
    protect = 1'b0;
    // fifteen steps from 2001 leave the window and land on user word 010
    repeat (15) i_prog.send_cmd(`SPVP_CMD_INC_ADDR, 48);
    write_word(`SPVP_CMD_LOAD_DATA, 14'h2b6d);
    i_prog.leave();
    i_prog.enter();
    @(negedge mclk);
    protect = 1'b1;
    read_at("user_protected", 14'h0000);
    @(negedge mclk);
    protect = 1'b0;
    read_at("user_back", 14'h1a5c);
    // a config write that leaked into user space would show at word 1
    i_prog.send_cmd(`SPVP_CMD_INC_ADDR, 48);
    read_at("user_addr1", 14'h0731);
    repeat (15) i_prog.send_cmd(`SPVP_CMD_INC_ADDR, 48);
    read_at("user_alias", 14'h2b6d);
  endtask
  initial begin
    repeat (10) @(negedge mclk);
    rst_b = 1'b1;
    t_entry();
    t_user();
    t_reenter();
    t_unknown();
    t_config();
    final_report();
  end
endmodule
